// >>> autoneg_pkg.sv
package autoneg_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int TECH_W = 4;
    localparam int SEL_W = 5;
    // register offsets on the management register port
    localparam logic [4:0] ADV_ADDR = 5'h04;
    localparam logic [4:0] PARTNER_ADDR = 5'h05;
    // field positions; bit 14 is acknowledge in the partner register, reserved in the advertisement
    localparam int NEXT_PAGE_BIT = 15;
    localparam int ACK_BIT = 14;
    localparam int RSV_RO_BIT = 14;
    localparam int REMOTE_FAULT_BIT = 13;
    localparam int RSV_RW_BIT = 12;
    localparam int ASYM_PAUSE_BIT = 11;
    localparam int PAUSE_BIT = 10;
    localparam int T4_BIT = 9;
    localparam int TECH_LO = 5;
    localparam int SEL_LO = 0;
    // selector codes
    localparam logic [4:0] SEL_IEEE_8023 = 5'h01;
    localparam logic [4:0] SEL_IEEE_8029 = 5'h02;
    localparam logic [4:0] SEL_RSV_LO = 5'h00;
    localparam logic [4:0] SEL_RSV_HI = 5'h1f;
    // advertisement reset value before straps; writable bit mask
    localparam logic [15:0] ADV_RESET = 16'h0001;
    localparam logic [15:0] ADV_WR_MASK = 16'hbfff;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;
    // strap capture: synchroniser depth
    localparam int STRAP_SYNC_STAGES = 2;
    typedef enum logic [1:0] {SEL_NONE, SEL_ADV, SEL_PARTNER} regsel_t;
endpackage

// >>> strap_if.sv
`timescale 1ns/100ps
interface strap_if;
    logic load;
    logic pause;
    logic [3:0] tech;
    modport src (output load, output pause, output tech);
    modport dst (input load, input pause, input tech);
endinterface

// >>> strap_capture.sv
`timescale 1ns/100ps
module strap_capture
    import autoneg_pkg::*;
(
    input wire logic clock, // 10 MHz
    input wire logic rstn, // async reset, low
    input wire logic ce, // clock enable
    input wire logic pauseStrap, // pause default pin
    input wire logic [TECH_W-1:0] strapConfigPins, // technology straps
    strap_if.src strap // captured levels to the register bank
);
    typedef enum {WAIT_SYNC, WAIT_SETTLE, CAPTURE, LOAD, DONE} capstate_t;
    capstate_t state_q;
    logic [TECH_W:0] sync1_q;
    logic [TECH_W:0] sync2_q;

    ////////////////////////////////////////////////////////////////////
    // two-stage synchroniser on the strap pins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= {pauseStrap, strapConfigPins};
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wait until both stages hold pin levels, then load once
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= WAIT_SYNC;
        end else if (ce) begin
            case (state_q)
                WAIT_SYNC: state_q <= WAIT_SETTLE;
                WAIT_SETTLE: state_q <= CAPTURE;
                CAPTURE: state_q <= LOAD;
                LOAD: state_q <= DONE;
                DONE: state_q <= DONE;
                default: state_q <= DONE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strap.pause <= 1'b0;
            strap.tech <= '0;
        end else if (ce && state_q == CAPTURE) begin
            // second stage holds pin levels only from the second edge on
            strap.pause <= sync2_q[TECH_W];
            strap.tech <= sync2_q[TECH_W-1:0];
        end
    end

    assign strap.load = (state_q == LOAD);
endmodule

// >>> autoneg_ability_registers.sv
`timescale 1ns/100ps
// Notes on behaviour
// - next-page advertise bit, read/write, resets to zero
// - remote-fault advertise bit, read/write, resets to zero
// - bit 14 reads zero always; bit 12 writable, resets zero
// - asymmetric pause advertise bit, read/write, resets zero, sent in page
// - pause advertise bit, read/write, one means full-duplex pause enabled
// - pause bit default is loaded from its strap pin at reset
// - 100BASE-T4 advertise bit is writable though unsupported, resets zero
// - four technology bits 8..5: TX-FD, TX, 10-FD, 10, read/write
// - technology defaults come from the strap configuration pins at reset
// - selector resets to 00001; host must avoid reserved codes
// - partner bits 15,14 report next page and acknowledge
// - partner bits 11,10 report asymmetric pause and pause
// - partner bits 9..5 report T4 and the four technology abilities
// - partner selector in bits 4..0, remote fault in bit 13
// - received base page loads partner register and raises page-received
module autoneg_ability_registers
    import autoneg_pkg::*;
(
    input wire logic clock, // 10 MHz
    input wire logic rstn, // async reset, low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic pauseStrap, // pause default strap pin
    input wire logic [TECH_W-1:0] strapConfigPins, // technology straps
    input wire logic [ADDR_W-1:0] regAddr, // management register address
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    input wire logic [DATA_W-1:0] regWrData, // write data
    output logic [DATA_W-1:0] regRdData, // read data, one cycle later
    input wire logic pageRxValid, // base page received pulse
    input wire logic [DATA_W-1:0] pageRxWord, // received link code word
    output logic pageReceived, // page-received indication pulse
    input wire logic anStart, // negotiation start or restart pulse
    output logic [DATA_W-1:0] txBaseWord // base word for transmission
);
    strap_if strapBus ();
    logic [DATA_W-1:0] adv_q;
    logic [DATA_W-1:0] partner_q;
    logic [DATA_W-1:0] advView;
    logic advWrite;

    function automatic regsel_t decodeAddr(input logic [ADDR_W-1:0] a);
        if (a == ADV_ADDR) begin
            return SEL_ADV;
        end else if (a == PARTNER_ADDR) begin
            return SEL_PARTNER;
        end
        return SEL_NONE;
    endfunction

    strap_capture straps (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .pauseStrap(pauseStrap),
        .strapConfigPins(strapConfigPins),
        .strap(strapBus.src)
    );

    ////////////////////////////////////////////////////////////////////
    // local advertisement register
    assign advWrite = regWrite && decodeAddr(regAddr) == SEL_ADV;
    // bit 14 never stores a one
    assign advView = adv_q & ADV_WR_MASK;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            adv_q <= ADV_RESET;
        end else if (ce) begin
            if (advWrite) begin
                // all fields but bit 14 take the host value
                adv_q <= regWrData & ADV_WR_MASK;
            end else if (strapBus.load) begin
                adv_q[PAUSE_BIT] <= strapBus.pause;
                adv_q[TECH_LO +: TECH_W] <= strapBus.tech;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // partner ability register: no reset, loaded only by received pages
    always_ff @(posedge clock) begin
        if (ce && pageRxValid) begin
            partner_q <= pageRxWord;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pageReceived <= 1'b0;
        end else if (ce) begin
            pageReceived <= pageRxValid;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit word taken at negotiation start
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            txBaseWord <= ADV_RESET;
        end else if (ce && anStart) begin
            txBaseWord <= advView;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdData <= RD_UNMAPPED;
        end else if (ce && regRead) begin
            case (decodeAddr(regAddr))
                SEL_ADV: regRdData <= advView;
                SEL_PARTNER: regRdData <= partner_q;
                default: regRdData <= RD_UNMAPPED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // field map must tile bits 0 to 10 and keep bit 14 unwritable
    if (SEL_LO + SEL_W != TECH_LO
            || TECH_LO + TECH_W != T4_BIT
            || T4_BIT + 1 != PAUSE_BIT
            || ADV_WR_MASK[RSV_RO_BIT] != 1'b0) begin : g_mapCheck
        $error("advertisement field map does not tile the word");
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence s_advWrite;
        ce && advWrite;
    endsequence

    sequence s_advRead;
        ce && regRead && regAddr == ADV_ADDR && !regWrite;
    endsequence

    property p_rsvZero;
        s_advRead |=> regRdData[RSV_RO_BIT] == 1'b0;
    endproperty
    a_rsvZero: assert property (p_rsvZero)
        else $error("reserved bit 14 read back as one");

    property p_writeReadBack;
        s_advWrite ##1 s_advRead
            |=> regRdData == ($past(regWrData, 2) & ADV_WR_MASK);
    endproperty
    a_writeReadBack: assert property (p_writeReadBack)
        else $error("advertisement read differs from value written");

    property p_partnerReadOnly;
        ce && regWrite && regAddr == PARTNER_ADDR && !pageRxValid
            |=> $stable(partner_q);
    endproperty
    a_partnerReadOnly: assert property (p_partnerReadOnly)
        else $error("partner register changed on a host write");

    property p_pageLoad;
        ce && pageRxValid |=> partner_q == $past(pageRxWord)
            && pageReceived;
    endproperty
    a_pageLoad: assert property (p_pageLoad)
        else $error("received page not loaded or not flagged");

    property p_pageFlagCause;
        pageReceived |-> ($past(ce) ? $past(pageRxValid)
            : $past(pageReceived));
    endproperty
    a_pageFlagCause: assert property (p_pageFlagCause)
        else $error("page-received raised without a received page");

    property p_partnerRead;
        ce && regRead && regAddr == PARTNER_ADDR
            |=> regRdData == $past(partner_q);
    endproperty
    a_partnerRead: assert property (p_partnerRead)
        else $error("partner register read returned wrong word");

    property p_txOnStart;
        ce && anStart |=> txBaseWord == $past(advView);
    endproperty
    a_txOnStart: assert property (p_txOnStart)
        else $error("transmit word not taken at negotiation start");

    property p_txHold;
        !(ce && anStart) |=> $stable(txBaseWord);
    endproperty
    a_txHold: assert property (p_txHold)
        else $error("transmit word changed without a start");

    property p_strapLoad;
        ce && strapBus.load && !advWrite
            |=> adv_q[PAUSE_BIT] == $past(strapBus.pause)
            && adv_q[TECH_LO +: TECH_W] == $past(strapBus.tech);
    endproperty
    a_strapLoad: assert property (p_strapLoad)
        else $error("strap levels not loaded into advertisement");

    property p_unmapped;
        ce && regRead && decodeAddr(regAddr) == SEL_NONE
            |=> regRdData == RD_UNMAPPED;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address read nonzero");

    property p_freeze;
        !ce |=> $stable(adv_q) && $stable(regRdData)
            && $stable(pageReceived);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state changed while clock enable low");

    // straps land once, so later host writes are never overridden
    property p_strapOnce;
        ce && strapBus.load |=> !strapBus.load;
    endproperty
    a_strapOnce: assert property (p_strapOnce)
        else $error("strap load pulse lasted more than one cycle");

    property p_partnerWriteNoAdv;
        ce && regWrite && regAddr == PARTNER_ADDR && !strapBus.load
            |=> $stable(adv_q);
    endproperty
    a_partnerWriteNoAdv: assert property (p_partnerWriteNoAdv)
        else $error("write to partner register altered advertisement");
endmodule

// >>> link_partner_model.sv
`timescale 1ns/100ps
module link_partner_model
    import autoneg_pkg::*;
(
    input wire logic clock, // bench clock
    output logic pageRxValid, // base page strobe
    output logic [DATA_W-1:0] pageRxWord // received code word
);
    initial begin
        pageRxValid = 1'b0;
        pageRxWord = 16'h5555;
    end
    // one base page per call; keep holds the strobe for a following page
    task automatic send(input logic [DATA_W-1:0] w, input logic keep);
        @(negedge clock);
        pageRxValid = 1'b1;
        pageRxWord = w;
        if (!keep) begin
            @(negedge clock);
            pageRxValid = 1'b0;
            // stale word inverted so it can never pass for fresh data
            pageRxWord = ~w;
        end
    endtask
endmodule

// >>> tb_autoneg_ability_registers.sv
`timescale 1ns/100ps
module tb_autoneg_ability_registers;
    import autoneg_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic pauseStrap = 1'b1;
    logic [TECH_W-1:0] strapConfigPins = 4'ha;
    logic [ADDR_W-1:0] regAddr = 5'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regWrData = 16'h0000;
    logic [DATA_W-1:0] regRdData;
    logic pageRxValid;
    logic [DATA_W-1:0] pageRxWord;
    logic pageReceived;
    logic anStart = 1'b0;
    logic [DATA_W-1:0] txBaseWord;
    int err_count = 0;
    int check_count = 0;

    autoneg_ability_registers autoneg_ability_registers_inst (
        .clock(clock), .rstn(rstn), .ce(ce), .pauseStrap(pauseStrap),
        .strapConfigPins(strapConfigPins), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
        .regRdData(regRdData), .pageRxValid(pageRxValid),
        .pageRxWord(pageRxWord), .pageReceived(pageReceived),
        .anStart(anStart), .txBaseWord(txBaseWord));
    link_partner_model link_partner_model_inst (
        .clock(clock), .pageRxValid(pageRxValid), .pageRxWord(pageRxWord));

    initial begin
        forever #50 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
    endtask
    // write, then read the same address on the very next edge
    task automatic wrrd(input logic [4:0] a, input logic [15:0] d,
                        input logic [15:0] exp, input string what);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        chk(what, exp, regRdData);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp,
                      input string what);
        @(negedge clock);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        chk(what, exp, regRdData);
    endtask
    task automatic do_reset(input logic p, input logic [3:0] t);
        @(negedge clock);
        rstn = 1'b0;
        pauseStrap = p;
        strapConfigPins = t;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (4) @(negedge clock);
    endtask
    function automatic logic [15:0] strapped(input logic p,
                                             input logic [3:0] t);
        return ADV_RESET | (16'(p) << PAUSE_BIT) | (16'(t) << TECH_LO);
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b1, 4'ha);
        chk("tx word at reset", 16'h0001, txBaseWord);
        rd(ADV_ADDR, strapped(1'b1, 4'ha), "adv strap a");
        $display("test straps done");
        wr(ADV_ADDR, 16'hffe1);
        rd(ADV_ADDR, 16'hbfe1, "adv ones");
        wrrd(ADV_ADDR, 16'h0002, 16'h0002, "adv zeros");
        wr(ADV_ADDR, 16'h5802);
        rd(ADV_ADDR, 16'h1802, "adv reserved");
        rd(5'h1f, RD_UNMAPPED, "unmapped read");
        $display("test writes done");
        @(negedge clock);
        anStart = 1'b1;
        @(negedge clock);
        anStart = 1'b0;
        chk("tx word", 16'h1802, txBaseWord);
        ce = 1'b0;
        wr(ADV_ADDR, 16'h8421);
        ce = 1'b1;
        rd(ADV_ADDR, 16'h1802, "adv frozen");
        wr(ADV_ADDR, 16'h8421);
        chk("tx word held", 16'h1802, txBaseWord);
        $display("test start done");
        link_partner_model_inst.send(16'hc5e1, 1'b0);
        chk("page flag", 16'h0001, {15'h0, pageReceived});
        @(negedge clock);
        chk("page flag end", 16'h0000, {15'h0, pageReceived});
        rd(PARTNER_ADDR, 16'hc5e1, "partner a");
        wr(PARTNER_ADDR, 16'h1234);
        rd(PARTNER_ADDR, 16'hc5e1, "partner wr");
        link_partner_model_inst.send(16'h0001, 1'b1);
        link_partner_model_inst.send(16'h3a1f, 1'b0);
        chk("page flag b", 16'h0001, {15'h0, pageReceived});
        rd(PARTNER_ADDR, 16'h3a1f, "partner b");
        rd(ADV_ADDR, 16'h8421, "adv untouched");
        $display("test partner done");
        do_reset(1'b0, 4'h5);
        chk("tx word reset 2", 16'h0001, txBaseWord);
        rd(ADV_ADDR, strapped(1'b0, 4'h5), "adv strap 5");
        $display("test second reset done");
        close_out();
    end
    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        close_out();
    end
endmodule
